/* File: rtl/pmsd_pkg.sv */
// Constants, types and the mode table of the strap decoder.
// Assumes a 50 MHz clock and a strap level given in millivolts by an ADC.
//
// Contract
// - While reset is low and during power-up the block stays inactive with the pass switch off.
// - On leaving power-up the block takes exactly one sample of the strap level as its mode.
// - The sample maps to sixteen bands that fix type, placement, power and class options.
// - Bands 4 to 7 and 12 to 15 restart by themselves, the rest only after disconnect.
// - In auto-restart the time from a fault to new detection is at least 2.0 s.
// - Once the mode is sampled the shared pin is driven as the status LED output.
// - The latched mode never changes during operation; only a reset takes a new strap.
// - After power-up detection starts with the switch off, and the switch turns on only after a valid detection.
// - In restart-after-disconnect mode detection resumes only when the port reads above 150 kOhm.
package pmsd_pkg;

  localparam int unsigned CLK_KHZ        = 50000;
  localparam int unsigned T_RESTART_MS   = 2000;
  localparam int unsigned T_LED_SLOW_MS  = 333;
  localparam int unsigned T_LED_FAST_MS  = 50;
  localparam int unsigned RESTART_CYC    = T_RESTART_MS * CLK_KHZ;
  localparam int unsigned LED_SLOW_CYC   = T_LED_SLOW_MS * CLK_KHZ;
  localparam int unsigned LED_FAST_CYC   = T_LED_FAST_MS * CLK_KHZ;
  localparam logic [2:0]  SETTLE_CYC     = 3'h3;

  localparam int          MV_W           = 12;
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_MODE      = 4'h8;
  localparam logic        CTRL_RST       = 1'h1;
  localparam int          CTRL_DET_EN    = 0;
  localparam int          ST_VALID_BIT   = 0;
  localparam int          ST_SWITCH_BIT  = 1;
  localparam int          ST_STATE_LSB   = 4;
  localparam int          MD_ENDPT_BIT   = 4;
  localparam int          MD_AUTO_BIT    = 5;
  localparam int          MD_TYPE2_BIT   = 6;
  localparam int          MD_PWR_LSB     = 7;
  localparam int          MD_CLASS_BIT   = 9;
  localparam int          MD_MARK_BIT    = 10;

  localparam logic [1:0]  PWR_7W         = 2'h0;
  localparam logic [1:0]  PWR_15W4       = 2'h1;
  localparam logic [1:0]  PWR_30W        = 2'h2;

  typedef logic [MV_W-1:0] pmsd_mv_t;

  localparam pmsd_mv_t BAND_EDGE_MV [15] = '{
    12'h07a, 12'h152, 12'h224, 12'h2f4, 12'h3c1, 12'h48a, 12'h556, 12'h627,
    12'h6f8, 12'h7c6, 12'h894, 12'h967, 12'ha3a, 12'hb16, 12'hbe4};

  typedef enum logic [2:0] {
    PMSD_OFF, PMSD_SAMPLE, PMSD_DETECT, PMSD_POWER, PMSD_WAIT, PMSD_HOLD
  } pmsd_state_t;

  typedef struct packed {
    logic       endpoint;
    logic       auto_rst;
    logic       type2;
    logic [1:0] power;
    logic       class_bom;
    logic       mark_bom;
  } pmsd_mode_t;

  // The four bands of each group repeat the same type, power and class pattern.
  function automatic pmsd_mode_t pmsd_mode_of(input logic [3:0] band);
    pmsd_mode_t m;
    m.endpoint  = band[3];
    m.auto_rst  = band[2];
    m.type2     = (band[1:0] == 2'h0) || (band[1:0] == 2'h3);
    m.power     = (band[1:0] == 2'h1) ? PWR_7W : (band[1:0] == 2'h2) ? PWR_15W4 : PWR_30W;
    m.class_bom = band[0];
    m.mark_bom  = (band[1:0] == 2'h3);
    return m;
  endfunction

endpackage

/* File: rtl/pmsd_strap_if.sv */
// Carries the synchronised strap level to the band decoder and the band back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pmsd_strap_if;
  import pmsd_pkg::*;
  pmsd_mv_t   mv;
  logic [3:0] band;
  modport dec  (input mv, output band);
  modport user (output mv, input band);
endinterface
`default_nettype wire

/* File: rtl/pmsd_band_dec.sv */
// Combinational decoder from strap millivolts to one of sixteen bands.
// Assumes the level is already stable in the clock domain.
`timescale 1ns/1ps
`default_nettype none
module pmsd_band_dec
  import pmsd_pkg::*;
(
  pmsd_strap_if.dec s
);
  logic [3:0] band;

  // Edges rise, so the last edge reached wins; an equal level counts as reached.
  always_comb begin
    band = 4'h0;
    for (int i = 0; i < 15; i++) begin
      if (s.mv >= BAND_EDGE_MV[i]) begin
        band = 4'(i + 1);
      end
    end
  end

  assign s.band = band;
endmodule
`default_nettype wire

/* File: rtl/pmsd_mode_strap_decoder.sv */
// Reset handling, strap sampling and restart sequencing of a single PSE port.
// Assumes an ADC code of the strap pin in millivolts and front-end flags from pins.
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pmsd_mode_strap_decoder
  import pmsd_pkg::*;
#(
  parameter int unsigned P_RESTART_CYC = RESTART_CYC,
  parameter int unsigned P_SLOW_CYC    = LED_SLOW_CYC,
  parameter int unsigned P_FAST_CYC    = LED_FAST_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire pmsd_mv_t    i_strap_mv,
  input  wire logic        i_det_ok,
  input  wire logic        i_fault,
  input  wire logic        i_port_open,
  output logic             o_pass_switch,
  output logic             o_status_o,
  output logic             o_status_oe,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  pmsd_strap_if strap ();

  pmsd_mv_t    mv_m_q, mv_s_q;
  logic [2:0]  flg_m_q, flg_s_q;
  pmsd_state_t st_q, st_d;
  logic [2:0]  settle_q;
  logic [3:0]  band_q;
  logic        valid_q;
  logic [31:0] tmr_q;
  logic [31:0] blk_q;
  logic        det_en_q;
  logic        pass_q, led_q, oe_q;
  logic        wait_q;
  logic [31:0] rdata_q;

  // Pins from the analog front end are outside the clock domain.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mv_m_q  <= '0;
      mv_s_q  <= '0;
      flg_m_q <= 3'h0;
      flg_s_q <= 3'h0;
    end else begin
      mv_m_q  <= i_strap_mv;
      mv_s_q  <= mv_m_q;
      flg_m_q <= {i_port_open, i_fault, i_det_ok};
      flg_s_q <= flg_m_q;
    end
  end

  wire logic det_s  = flg_s_q[0];
  wire logic flt_s  = flg_s_q[1];
  wire logic open_s = flg_s_q[2];

  assign strap.mv = mv_s_q;

  pmsd_band_dec u_dec (
    .s (strap.dec)
  );

  wire pmsd_mode_t mode      = pmsd_mode_of(band_q);
  wire logic       tmr_done  = (tmr_q >= P_RESTART_CYC - 1);
  wire logic       settled   = (settle_q == SETTLE_CYC);

  // Sequencing of the port from reset through detection, power and restart.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      PMSD_OFF: begin
        if (settled) begin
          st_d = PMSD_SAMPLE;
        end
      end
      PMSD_SAMPLE: begin
        st_d = PMSD_DETECT;
      end
      PMSD_DETECT: begin
        if (det_en_q && det_s) begin
          st_d = PMSD_POWER;
        end
      end
      PMSD_POWER: begin
        if (flt_s) begin
          st_d = mode.auto_rst ? PMSD_WAIT : PMSD_HOLD;
        end
      end
      PMSD_WAIT: begin
        if (tmr_done) begin
          st_d = PMSD_DETECT;
        end
      end
      PMSD_HOLD: begin
        if (open_s) begin
          st_d = PMSD_DETECT;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q     <= PMSD_OFF;
      settle_q <= 3'h0;
      tmr_q    <= '0;
    end else begin
      st_q     <= st_d;
      settle_q <= settled ? settle_q : settle_q + 3'h1;
      tmr_q    <= (st_q == PMSD_WAIT) ? tmr_q + 32'h1 : 32'h0;
    end
  end

  // The band is taken once; nothing but reset reopens it, so a moved strap is ignored.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      band_q  <= 4'h0;
      valid_q <= 1'h0;
    end else if (st_q == PMSD_SAMPLE) begin
      band_q  <= strap.band;
      valid_q <= 1'h1;
    end
  end

  // LED: slow blink while searching, steady when powered, fast blink after a fault.
  wire logic [31:0] blk_top = (st_q == PMSD_DETECT) ? P_SLOW_CYC - 1 : P_FAST_CYC - 1;
  wire logic        blk_end = (blk_q >= blk_top);
  wire logic        led_d   = (st_q == PMSD_POWER) ? 1'h1 :
                              (st_q == PMSD_OFF || st_q == PMSD_SAMPLE) ? 1'h0 :
                              (blk_end ? !led_q : led_q);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blk_q  <= '0;
      led_q  <= 1'h0;
      oe_q   <= 1'h0;
      pass_q <= 1'h0;
    end else begin
      blk_q  <= blk_end ? 32'h0 : blk_q + 32'h1;
      led_q  <= led_d;
      oe_q   <= valid_q;
      pass_q <= (st_d == PMSD_POWER);
    end
  end

  assign o_pass_switch = pass_q;
  assign o_status_o    = led_q;
  assign o_status_oe   = oe_q;

  // Avalon slave with one wait state: the answer comes on the second edge of a request.
  wire logic req    = i_avs_read || i_avs_write;
  wire logic accept = req && !wait_q;
  wire logic wr_ctl = accept && i_avs_write && (i_avs_address == ADDR_CTRL);

  wire logic [31:0] rd_ctrl   = {31'h0, det_en_q};
  wire logic [31:0] rd_status = {25'h0, st_q, 2'h0, pass_q, valid_q};
  wire logic [31:0] rd_mode   = {21'h0, mode.mark_bom, mode.class_bom, mode.power,
                                 mode.type2, mode.auto_rst, mode.endpoint, band_q};
  wire logic [31:0] rd_mux    = (i_avs_address == ADDR_CTRL)   ? rd_ctrl   :
                                (i_avs_address == ADDR_STATUS) ? rd_status :
                                (i_avs_address == ADDR_MODE)   ? rd_mode   : 32'h0;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q   <= 1'h1;
      rdata_q  <= 32'h0;
      det_en_q <= CTRL_RST;
    end else begin
      wait_q   <= !(req && wait_q);
      rdata_q  <= (req && wait_q && i_avs_read) ? rd_mux : rdata_q;
      det_en_q <= wr_ctl ? i_avs_writedata[CTRL_DET_EN] : det_en_q;
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_OFF_SWITCH_LOW: assert property (
    (st_q == PMSD_OFF || st_q == PMSD_SAMPLE) |-> !o_pass_switch)
    else $error("Pass switch on before sampling finished.");

  AST_ONE_SAMPLE: assert property (
    (st_q == PMSD_SAMPLE) |=> (band_q == $past(strap.band)) && valid_q
      && (st_q == PMSD_DETECT))
    else $error("Strap sample not latched correctly.");

  AST_BAND_ENDS: assert property (
    ((strap.mv < 12'h07a) |-> (strap.band == 4'h0))
      and ((strap.mv >= 12'hbe4) |-> (strap.band == 4'hf))
      and ((strap.mv < 12'h627) |-> (strap.band < 4'h8)))
    else $error("Band decode wrong at range ends.");

  AST_RESTART_KIND: assert property (
    (st_q == PMSD_POWER && flt_s) |=>
      (st_q == (band_q[2] ? PMSD_WAIT : PMSD_HOLD)))
    else $error("Wrong restart policy after fault.");

  AST_RESTART_DELAY: assert property (
    (st_q == PMSD_WAIT && st_d != PMSD_WAIT) |-> (tmr_q == P_RESTART_CYC - 1))
    else $error("Restart wait left early.");

  AST_PIN_DRIVEN: assert property (
    valid_q |=> o_status_oe)
    else $error("Status pin not driven after sampling.");

  AST_MODE_FROZEN: assert property (
    valid_q |=> $stable(band_q))
    else $error("Latched mode changed during operation.");

  AST_SWITCH_AFTER_DET: assert property (
    $rose(o_pass_switch) |-> $past(st_q == PMSD_DETECT && det_s && det_en_q))
    else $error("Pass switch on without valid detection.");

  AST_HOLD_UNTIL_OPEN: assert property (
    (st_q == PMSD_HOLD && !open_s) |=> (st_q == PMSD_HOLD) && !o_pass_switch)
    else $error("Detection resumed without disconnect.");

  AST_EDGE_HIGH: assert property (
    (strap.mv == 12'h07a) |-> (strap.band == 4'h1))
    else $error("Band edge not given to higher band.");

  AST_BUS_ONE_WAIT: assert property (
    (req && wait_q) |=> !o_avs_waitrequest)
    else $error("Bus answer not after one wait state.");

  COV_POWERED: cover property ((st_q == PMSD_DETECT) ##1 (st_q == PMSD_POWER));
  COV_AUTO_BACK: cover property ((st_q == PMSD_WAIT) ##1 (st_q == PMSD_DETECT));
  COV_DISC_BACK: cover property ((st_q == PMSD_HOLD) ##1 (st_q == PMSD_DETECT));
  COV_MODE_READ: cover property (!o_avs_waitrequest && i_avs_read && i_avs_address == ADDR_MODE);
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench of the strap decoder: reset, band decode, restart paths and register bus.
// Assumes the design package and shortened restart and LED counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmsd_pkg::*;
  localparam int unsigned RST_CYC = 20;
  logic        i_clk           = 1'b0;
  logic        i_rst_n         = 1'b0;
  pmsd_mv_t    i_strap_mv      = 12'h000;
  logic        i_det_ok        = 1'b0;
  logic        i_fault         = 1'b0;
  logic        i_port_open     = 1'b0;
  logic [3:0]  i_avs_address   = 4'h0;
  logic        i_avs_read      = 1'b0;
  logic        i_avs_write     = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic        o_pass_switch;
  logic        o_status_o;
  logic        o_status_oe;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  int          fails           = 0;
  int          num_checks      = 0;
  int          cyc             = 0;

  always #10 i_clk = ~i_clk;

  pmsd_mode_strap_decoder #(.P_RESTART_CYC(RST_CYC), .P_SLOW_CYC(8), .P_FAST_CYC(4)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_strap_mv(i_strap_mv), .i_det_ok(i_det_ok),
    .i_fault(i_fault), .i_port_open(i_port_open), .o_pass_switch(o_pass_switch),
    .o_status_o(o_status_o), .o_status_oe(o_status_oe), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest));

  task automatic close_out();
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The ceiling leaves ample room over the well under two thousand cycles the tests need.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus cycle; an idle edge follows so the next request never lands in the same step.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    i_avs_address   <= a;
    i_avs_writedata <= wd;
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    rd = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    chk("bus answer", n < 50, 1);
    @(posedge i_clk);
  endtask

  task automatic restart(input pmsd_mv_t mv);
    i_rst_n     <= 1'b0;
    i_strap_mv  <= mv;
    i_det_ok    <= 1'b0;
    i_fault     <= 1'b0;
    i_port_open <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
    chk("reset pass", {o_pass_switch, o_status_o, o_status_oe, o_avs_waitrequest}, 4'h1);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (10) @(posedge i_clk);
  endtask

  task automatic wt_pass(input logic v);
    int n;
    n = 0;
    while (o_pass_switch !== v && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    chk("pass_switch", o_pass_switch, v);
  endtask

  task automatic wt_state(input logic [2:0] s, output int d);
    logic [31:0] r;
    int t0;
    t0 = cyc;
    r  = '0;
    for (int i = 0; i < 100 && r[6:4] !== s; i++) begin
      bus(1'b0, ADDR_STATUS, 32'h0, r);
    end
    d = cyc - t0;
    chk("state", r[6:4], s);
  endtask

  function automatic logic [31:0] exp_mode(input int b);
    logic [1:0] p;
    logic [1:0] pw;
    p  = b[1:0];
    pw = (p == 2'h1) ? PWR_7W : (p == 2'h2) ? PWR_15W4 : PWR_30W;
    return {21'h0, p == 2'h3, p[0], pw, p == 2'h0 || p == 2'h3, b[2], b[3], p == p ? b[3:0] : 4'h0};
  endfunction

  task automatic t_decode();
    logic [31:0] r;
    pmsd_mv_t mv;
    for (int b = 0; b < 16; b++) begin
      for (int k = 0; k < 2; k++) begin
        mv = k ? ((b == 15) ? 12'hfff : BAND_EDGE_MV[b] - 12'h001)
               : ((b == 0) ? 12'h000 : BAND_EDGE_MV[b-1]);
        restart(mv);
        bus(1'b0, ADDR_MODE, 32'h0, r);
        chk("mode", r, exp_mode(b));
        chk("status_oe", o_status_oe, 1);
        bus(1'b0, ADDR_STATUS, 32'h0, r);
        chk("mode valid", r[ST_VALID_BIT], 1);
        i_strap_mv <= ~mv;
        repeat (8) @(posedge i_clk);
        bus(1'b1, ADDR_MODE, 32'h0, r);
        bus(1'b0, ADDR_MODE, 32'h0, r);
        chk("mode held", r, exp_mode(b));
      end
    end
  endtask

  task automatic t_fault(input pmsd_mv_t mv);
    int d;
    int n;
    logic l;
    restart(mv);
    wt_state(3'h2, d);
    chk("pass before detect", o_pass_switch, 0);
    l = o_status_o;
    n = 0;
    while (o_status_o === l && n < 12) begin
      @(posedge i_clk);
      n++;
    end
    chk("led blink", n < 12, 1);
    i_det_ok <= 1'b1;
    wt_pass(1'b1);
    @(posedge i_clk);
    chk("led powered", o_status_o, 1);
    i_det_ok <= 1'b0;
    i_fault  <= 1'b1;
    wt_pass(1'b0);
    i_fault  <= 1'b0;
  endtask

  task automatic t_restart();
    int d;
    logic [31:0] r;
    t_fault(BAND_EDGE_MV[3]);
    wt_state(3'h2, d);
    chk("restart delay", d >= RST_CYC, 1);
    t_fault(12'h000);
    wt_state(3'h5, d);
    repeat (3 * RST_CYC) @(posedge i_clk);
    bus(1'b0, ADDR_STATUS, 32'h0, r);
    chk("hold state", r[6:4], 3'h5);
    i_port_open <= 1'b1;
    wt_state(3'h2, d);
    chk("pass after restart", o_pass_switch, 0);
    bus(1'b0, 4'hc, 32'h0, r);
    chk("unmapped read", r, 32'h0);
  endtask

  initial begin
    @(posedge i_clk);
    t_decode();
    t_restart();
    close_out();
  end
endmodule
`default_nettype wire
